// [verilog/serializer_cfg_pkg.sv]
// Constants and types of the serializer strap configuration loader.
// Assumes one 25 MHz clock and a byte-wide register port on the same clock.
//
// Behaviour
// - Straps are captured into register bits at power-up, then readable and writable.
// - Pixel-width strap is stored inverted in bit 6 of register 0x4F.
// - Auto sleep strap is stored as is in bit 7 of register 0x01.
// - Repeater strap is stored as is in bit 5 of register 0xC2.
// - Bit-mapping strap is stored as is in bit 7 of register 0x4F.
// - Cable-medium strap is stored as is in bit 7 of register 0x5B.
// - Pixel-width value 0 takes single-pixel input, 1 takes dual-pixel input.
// - Auto sleep is off while its value is 0, on while 1.
// - Repeater operation is off while its value is 0, on while 1.
// - Mapping value 0 selects standard mapping, 1 selects SPWG with LSBs on D3/D7.
// - Cable value 0 selects twisted pair, 1 selects coaxial cable.
// - Second strap levels 1-2, 3-4, 5-6, 7-8 give mapping/cable 00, 01, 10, 11.
// - Register 0x5B bits 1:0 select single, dual, replicate or auto-detect.
// - Link-mode value 1 selects single-link operation.
// - Auto-detect picks mode from receiver capability and delivered video format.
package serializer_cfg_pkg;
   // ----------------------------------------
   // Register offsets and fields
   // ----------------------------------------
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_SLEEP = 8'h01;
   localparam logic [7:0] ADDR_PIXEL = 8'h4F;
   localparam logic [7:0] ADDR_LINK = 8'h5B;
   localparam logic [7:0] ADDR_REPEAT = 8'hC2;
   localparam int BIT_AUTO_SLEEP = 7;
   localparam int BIT_PIXEL_WIDTH = 6;
   localparam int BIT_BIT_MAP = 7;
   localparam int BIT_CABLE = 7;
   localparam int BIT_REPEATER = 5;
   localparam int BIT_STRAP_DONE = 0;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam logic [7:0] LINK_RESET_VALUE = 8'h00;
   // ----------------------------------------
   // Link modes
   // ----------------------------------------
   localparam logic [1:0] LINK_AUTO = 2'h0;
   localparam logic [1:0] LINK_SINGLE = 2'h1;
   localparam logic [1:0] LINK_DUAL = 2'h2;
   localparam logic [1:0] LINK_REPLICATE = 2'h3;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLOCK_PERIOD_NS = 40;
   localparam int STRAP_SETTLE_NS = 160;
   localparam int SETTLE_CYCLES_INT = (STRAP_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam logic [3:0] SETTLE_CYCLES = 4'(SETTLE_CYCLES_INT);
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic {WAIT_STRAP, STRAP_LOADED} phase_e;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;
   typedef struct packed {
      logic pixel_dual;
      logic auto_sleep_en;
      logic repeater_en;
      logic bit_map_spwg;
      logic cable_coax;
      logic [1:0] link_mode;
   } config_s;
endpackage

// [verilog/serializer_strap_cfg.sv]
// Strap capture and configuration register bits of the serializer.
// Assumes strap level codes arrive asynchronously from the board level decoder.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module serializer_strap_cfg (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic [2:0] STRAP_INPUT_FIRST,
   input wire logic [2:0] STRAP_INPUT_SECOND,
   input wire serializer_cfg_pkg::reg_req_s REG_REQ,
   output logic [7:0] REG_RDATA,
   input wire logic RX_DUAL_CAPABLE,
   input wire logic VIDEO_DUAL_PIXEL,
   output serializer_cfg_pkg::config_s CONFIG,
   output logic STRAP_DONE
);
   import serializer_cfg_pkg::*;

   typedef struct packed {
      logic [2:0] first_meta;
      logic [2:0] first_sync;
      logic [2:0] second_meta;
      logic [2:0] second_sync;
      phase_e phase;
      logic [3:0] settle;
      logic [7:0] reg_sleep;
      logic [7:0] reg_pixel;
      logic [7:0] reg_link;
      logic [7:0] reg_repeat;
      logic [7:0] rdata;
      config_s cfg;
   } state_s;

   state_s state;
   state_s next_state;
   logic pixel_strap;
   logic sleep_strap;
   logic repeat_strap;
   logic map_strap;
   logic cable_strap;

   // ----------------------------------------
   // Strap level decode
   // ----------------------------------------
   always_comb begin
      // Level code is level number minus one
      case (state.first_sync)
         3'h0: {pixel_strap, sleep_strap, repeat_strap} = 3'h1;
         3'h1: {pixel_strap, sleep_strap, repeat_strap} = 3'h2;
         3'h2: {pixel_strap, sleep_strap, repeat_strap} = 3'h3;
         3'h3: {pixel_strap, sleep_strap, repeat_strap} = 3'h4;
         3'h4: {pixel_strap, sleep_strap, repeat_strap} = 3'h2;
         3'h5: {pixel_strap, sleep_strap, repeat_strap} = 3'h6;
         default: {pixel_strap, sleep_strap, repeat_strap} = 3'h7;
      endcase
      {map_strap, cable_strap} = state.second_sync[2:1];
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_state.first_meta = STRAP_INPUT_FIRST;
      next_state.first_sync = state.first_meta;
      next_state.second_meta = STRAP_INPUT_SECOND;
      next_state.second_sync = state.second_meta;
      next_state.rdata = 8'h00;
      if (REG_REQ.wr) begin
         if (REG_REQ.addr == ADDR_SLEEP) begin
            next_state.reg_sleep = REG_REQ.wdata;
         end else if (REG_REQ.addr == ADDR_PIXEL) begin
            next_state.reg_pixel = REG_REQ.wdata;
         end else if (REG_REQ.addr == ADDR_LINK) begin
            next_state.reg_link = REG_REQ.wdata;
         end else if (REG_REQ.addr == ADDR_REPEAT) begin
            next_state.reg_repeat = REG_REQ.wdata;
         end
      end
      case (state.phase)
         WAIT_STRAP: begin
            if (state.settle == SETTLE_CYCLES) begin
               next_state.phase = STRAP_LOADED;
               next_state.reg_pixel[BIT_PIXEL_WIDTH] = ~pixel_strap;
               next_state.reg_sleep[BIT_AUTO_SLEEP] = sleep_strap;
               next_state.reg_repeat[BIT_REPEATER] = repeat_strap;
               next_state.reg_pixel[BIT_BIT_MAP] = map_strap;
               next_state.reg_link[BIT_CABLE] = cable_strap;
            end else begin
               next_state.settle = state.settle + 4'h1;
            end
         end
         default: begin
            next_state.phase = STRAP_LOADED;
         end
      endcase
      if (REG_REQ.rd) begin
         if (REG_REQ.addr == ADDR_STATUS) begin
            next_state.rdata = 8'h00;
            next_state.rdata[BIT_STRAP_DONE] = (state.phase == STRAP_LOADED);
         end else if (REG_REQ.addr == ADDR_SLEEP) begin
            next_state.rdata = state.reg_sleep;
         end else if (REG_REQ.addr == ADDR_PIXEL) begin
            next_state.rdata = state.reg_pixel;
         end else if (REG_REQ.addr == ADDR_LINK) begin
            next_state.rdata = state.reg_link;
         end else if (REG_REQ.addr == ADDR_REPEAT) begin
            next_state.rdata = state.reg_repeat;
         end else begin
            next_state.rdata = 8'h00;
         end
      end
      next_state.cfg.pixel_dual = ~state.reg_pixel[BIT_PIXEL_WIDTH];
      next_state.cfg.auto_sleep_en = state.reg_sleep[BIT_AUTO_SLEEP];
      next_state.cfg.repeater_en = state.reg_repeat[BIT_REPEATER];
      next_state.cfg.bit_map_spwg = state.reg_pixel[BIT_BIT_MAP];
      next_state.cfg.cable_coax = state.reg_link[BIT_CABLE];
      case (state.reg_link[1:0])
         LINK_SINGLE: next_state.cfg.link_mode = LINK_SINGLE;
         LINK_DUAL: next_state.cfg.link_mode = LINK_DUAL;
         LINK_REPLICATE: next_state.cfg.link_mode = LINK_REPLICATE;
         default: begin
            if (RX_DUAL_CAPABLE && VIDEO_DUAL_PIXEL) begin
               next_state.cfg.link_mode = LINK_DUAL;
            end else begin
               next_state.cfg.link_mode = LINK_SINGLE;
            end
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         state <= '0;
         state.phase <= WAIT_STRAP;
         state.reg_sleep <= RESET_VALUE;
         state.reg_pixel <= RESET_VALUE;
         state.reg_link <= LINK_RESET_VALUE;
         state.reg_repeat <= RESET_VALUE;
      end else begin
         state <= next_state;
      end
   end

   assign REG_RDATA = state.rdata;
   assign CONFIG = state.cfg;
   assign STRAP_DONE = (state.phase == STRAP_LOADED);
endmodule
`default_nettype wire

// [verification/link_receiver_model.sv]
// Downstream receiver model: reports dual-link capability.
// Assumes the bench sets the capability level.
`timescale 1ns/1ps
`default_nettype none
module link_receiver_model (
   input wire logic CLOCK,
   input wire logic dual_ok,
   output logic RX_DUAL_CAPABLE
);
   always_ff @(posedge CLOCK) RX_DUAL_CAPABLE <= dual_ok;
endmodule
`default_nettype wire

// [verification/strap_cfg_monitor.sv]
// Assertions on the ports of the strap configuration loader.
// Assumes one clock and the package compiled first.
`timescale 1ns/1ps
`default_nettype none
module strap_cfg_monitor
   import serializer_cfg_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire serializer_cfg_pkg::reg_req_s REG_REQ,
   input wire logic [7:0] REG_RDATA,
   input wire serializer_cfg_pkg::config_s CONFIG,
   input wire logic RX_DUAL_CAPABLE,
   input wire logic VIDEO_DUAL_PIXEL,
   input wire logic STRAP_DONE
);
   // ----
   // Checks
   // ----
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   sequence s_wr(logic [7:0] a);
      STRAP_DONE && REG_REQ.wr && REG_REQ.addr == a ##1 !(REG_REQ.wr && REG_REQ.addr == a);
   endsequence
   property p_link;
      s_wr(ADDR_LINK) |-> ##1 (CONFIG.link_mode == (($past(REG_REQ.wdata[1:0], 2) != LINK_AUTO)
         ? $past(REG_REQ.wdata[1:0], 2)
         : (($past(RX_DUAL_CAPABLE) && $past(VIDEO_DUAL_PIXEL)) ? LINK_DUAL : LINK_SINGLE)));
   endproperty
   a_link: assert property (p_link) else $error("link mode");
   property p_cable;
      s_wr(ADDR_LINK) |-> ##1 CONFIG.cable_coax == $past(REG_REQ.wdata[7], 2);
   endproperty
   a_cable: assert property (p_cable) else $error("cable bit");
   property p_pixel;
      s_wr(ADDR_PIXEL) |-> ##1 CONFIG.pixel_dual == !$past(REG_REQ.wdata[6], 2);
   endproperty
   a_pixel: assert property (p_pixel) else $error("pixel bit");
   property p_map;
      s_wr(ADDR_PIXEL) |-> ##1 CONFIG.bit_map_spwg == $past(REG_REQ.wdata[7], 2);
   endproperty
   a_map: assert property (p_map) else $error("map bit");
   property p_sleep;
      s_wr(ADDR_SLEEP) |-> ##1 CONFIG.auto_sleep_en == $past(REG_REQ.wdata[7], 2);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep bit");
   property p_repeat;
      s_wr(ADDR_REPEAT) |-> ##1 CONFIG.repeater_en == $past(REG_REQ.wdata[5], 2);
   endproperty
   a_repeat: assert property (p_repeat) else $error("repeater bit");
   property p_rdata;
      !$past(REG_REQ.rd) |-> REG_RDATA == 8'h00;
   endproperty
   a_rdata: assert property (p_rdata) else $error("idle read data");
   property p_hold;
      STRAP_DONE |=> STRAP_DONE;
   endproperty
   a_hold: assert property (p_hold) else $error("capture flag dropped");
   property p_time;
      $rose(RST_B) |-> ##[1:8] STRAP_DONE;
   endproperty
   a_time: assert property (p_time) else $error("capture late");
endmodule
bind serializer_strap_cfg strap_cfg_monitor mon (.CLOCK(CLOCK), .RST_B(RST_B), .REG_REQ(REG_REQ),
   .REG_RDATA(REG_RDATA), .CONFIG(CONFIG), .RX_DUAL_CAPABLE(RX_DUAL_CAPABLE),
   .VIDEO_DUAL_PIXEL(VIDEO_DUAL_PIXEL), .STRAP_DONE(STRAP_DONE));
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench of the strap configuration loader.
// Assumes package, design, receiver model and monitor compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import serializer_cfg_pkg::*;
   logic CLOCK = 1'b0;
   logic RST_B = 1'b0;
   logic [2:0] first = 3'h0;
   logic [2:0] second = 3'h0;
   reg_req_s req = '0;
   logic dual_ok = 1'b1;
   logic video_dual = 1'b1;
   logic rx_dual;
   logic [7:0] rdata;
   config_s cfg;
   logic done;
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;
   logic [2:0] tab [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h2, 3'h6, 3'h7, 3'h7};
   initial forever #20 CLOCK = ~CLOCK;
   serializer_strap_cfg dut (.CLOCK(CLOCK), .RST_B(RST_B), .STRAP_INPUT_FIRST(first), .STRAP_INPUT_SECOND(second),
      .REG_REQ(req), .REG_RDATA(rdata), .RX_DUAL_CAPABLE(rx_dual), .VIDEO_DUAL_PIXEL(video_dual),
      .CONFIG(cfg), .STRAP_DONE(done));
   link_receiver_model rx (.CLOCK(CLOCK), .dual_ok(dual_ok), .RX_DUAL_CAPABLE(rx_dual));
   // ----
   // Tasks
   // ----
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLOCK) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge CLOCK) req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge CLOCK) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge CLOCK) req.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge CLOCK) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         end_of_test();
      end
   end
   // ----
   // Tests
   // ----
   initial begin
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         @(posedge CLOCK);
         first <= c;
         second <= c;
         RST_B <= 1'b0;
         repeat (3) @(posedge CLOCK);
         RST_B <= 1'b1;
         for (int k = 0; k < 20 && done !== 1'b1; k++) @(posedge CLOCK);
         repeat (3) @(posedge CLOCK);
         chk({1'b0, cfg}, {1'b0, tab[c], c[2:1], LINK_DUAL});
         chk({7'h00, done}, 8'h01);
         rd(ADDR_SLEEP, {tab[c][1], 7'h00});
         rd(ADDR_REPEAT, {2'h0, tab[c][0], 5'h00});
         rd(ADDR_LINK, {c[1], 7'h00});
         @(posedge CLOCK);
         first <= ~c;
         second <= ~c;
         repeat (4) @(posedge CLOCK);
         rd(ADDR_PIXEL, {c[2], ~tab[c][2], 6'h00});
         $display("strap test %0d done", i);
      end
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_LINK, 8'(m));
         repeat (2) @(posedge CLOCK);
         chk({6'h00, cfg.link_mode}, m == 0 ? {6'h00, LINK_DUAL} : 8'(m));
      end
      dual_ok <= 1'b0;
      wr(ADDR_LINK, 8'h80);
      repeat (3) @(posedge CLOCK);
      chk({5'h00, cfg.cable_coax, cfg.link_mode}, {5'h01, LINK_SINGLE});
      dual_ok <= 1'b1;
      video_dual <= 1'b0;
      wr(ADDR_LINK, 8'h00);
      repeat (3) @(posedge CLOCK);
      chk({6'h00, cfg.link_mode}, {6'h00, LINK_SINGLE});
      wr(ADDR_PIXEL, 8'h40);
      wr(ADDR_SLEEP, 8'h00);
      wr(ADDR_REPEAT, 8'h00);
      repeat (2) @(posedge CLOCK);
      chk({4'h0, cfg[6:3]}, 8'h00);
      rd(ADDR_PIXEL, 8'h40);
      wr(8'h10, 8'hFF);
      rd(8'h10, 8'h00);
      wr(ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS, 8'h01);
      $display("register test done");
      end_of_test();
   end
endmodule
`default_nettype wire
